// file: ssr_far_end.sv
// Behavioural far-side synchronous serial device used by the port bench.
`timescale 1ns/1ns
module ssr_far_end (
   input  wire logic               clock_polarity_select,
   input  wire logic               drive,
   input  wire logic [8:0]         txVal,
   input  wire logic [3:0]         nBits,
   input  wire ssr_pkg::ssr_pins_s pins,
   output logic                    clkW,
   output logic                    datW
);
   import ssr_pkg::*;
   logic       farClk;
   logic       farDat;
   logic       inBit;
   logic [8:0] rxVal;
   int         idx;
   int         edges;
   int         frames;

   // With drive low, a released data line shows the inverse of the last bit, so a stale level never passes.
   assign clkW = pins.clkOe ? pins.clkOut : farClk;
   assign datW = pins.datOe ? pins.datOut : (drive ? farDat : ~farDat);

   initial begin
      farClk = 1'b0;
      farDat = 1'b0;
      inBit = 1'b0;
      rxVal = 9'h000;
      idx = 0;
      edges = 0;
      frames = 0;
   end

   // Leading edge leaves the idle level; a trailing edge only counts after a leading one.
   always @(clkW) begin
      if (clkW !== clock_polarity_select) begin
         farDat = txVal[idx];
         inBit = 1'b1;
         edges++;
      end else if (inBit) begin
         rxVal[idx] = datW;
         inBit = 1'b0;
         idx++;
         if (idx == int'(nBits)) begin
            idx = 0;
            frames++;
         end
      end
   end

   task automatic clr();
      idx = 0;
      edges = 0;
      frames = 0;
      inBit = 1'b0;
   endtask

   // The slave clock runs only inside a frame and rests at the idle level between frames.
   task automatic pulses(input int n);
      repeat (n) begin
         #80 farClk = ~clock_polarity_select;
         #80 farClk = clock_polarity_select;
      end
   endtask
endmodule

// file: ssr_pkg.sv
// Shared constants and types for the synchronous serial port block.
package ssr_pkg;
   // Register addresses on the plain register port.
   localparam logic [2:0] ADDR_BAUD   = 3'h0;
   localparam logic [2:0] ADDR_RXCTL  = 3'h1;
   localparam logic [2:0] ADDR_DIVLO  = 3'h2;
   localparam logic [2:0] ADDR_DIVHI  = 3'h3;
   localparam logic [2:0] ADDR_TXHOLD = 3'h4;
   localparam logic [2:0] ADDR_TXCTL  = 3'h5;
   localparam logic [2:0] ADDR_RXTOP  = 3'h6;
   localparam logic [2:0] ADDR_STAT   = 3'h7;
   // Bit positions in baud_rate_control.
   localparam int B_IDLE  = 6;
   localparam int B_CLOCK_POLARITY_SELECT  = 4;
   localparam int B_WIDE_RATE_DIVISOR = 3;
   // Bit positions in receive_status_control.
   localparam int R_PORT_ENABLE = 7;
   localparam int R_RX9  = 6;
   localparam int R_SINGLE_RECEIVE_ENABLE = 5;
   localparam int R_CONTINUOUS_RECEIVE_ENABLE = 4;
   localparam int R_OVERRUN_ERROR = 1;
   localparam int R_RECEIVED_NINTH_BIT = 0;
   // Bit positions in transmit_status_control.
   localparam int T_CLOCK_SOURCE_MASTER = 7;
   localparam int T_TX9  = 6;
   localparam int T_TRANSMIT_ENABLE = 5;
   localparam int T_SYNC = 4;
   localparam int T_HIGH_SPEED_RATE = 2;
   localparam int T_TRMT = 1;
   localparam int T_TRANSMIT_NINTH_BIT = 0;
   // Bit positions in the status register.
   localparam int S_HEMPTY = 1;
   localparam int S_RXFLAG = 0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] LAST_BIT8 = 4'h7;
   localparam logic [3:0] LAST_BIT9 = 4'h8;
   localparam logic [1:0] FIFO_FULL = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ACT   = 2'b01,
      ST_INACT = 2'b10
   } ssr_eng_e;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ssr_req_s;

   typedef struct packed {
      logic clkOut;
      logic clkOe;
      logic datOut;
      logic datOe;
   } ssr_pins_s;

   typedef struct packed {
      logic            clock_polarity_select, wide_rate_divisor, clock_source_master, tx9, transmit_enable, sync, high_speed_rate, transmit_ninth_bit;
      logic            port_enable, rx9, single_receive_enable, continuous_receive_enable, overrun_error, oerrSingle;
      logic [7:0]      divLo, divHi;
      logic [1:0][8:0] mem;
      logic            wrPtr, rdPtr;
      logic [1:0]      cnt;
      logic [7:0]      hold;
      logic            holdFull;
   } ssr_ctl_s;

   typedef struct packed {
      ssr_eng_e   st;
      logic [15:0] half;
      logic [3:0]  bitCnt;
      logic [8:0]  transmit_shifter;
      logic [8:0]  receive_shift_register;
      logic        busy;
      logic        datBit;
      logic        clkPrev;
   } ssr_eng_s;
endpackage

// file: ssr_port.sv
// Synchronous serial port: master/slave shifter, receive FIFO, registers.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
module ssr_port (
   input  wire logic              core_clk,
   input  wire logic              reset,
   input  wire logic              clkEn,
   input  wire ssr_pkg::ssr_req_s regReq,
   output ssr_pkg::ssr_pins_s     pins_ff,
   output logic [7:0]             regRdData_ff,
   output logic                   rxFlag_ff,
   input  wire logic              clockPinIn,
   input  wire logic              dataPinIn
);
   import ssr_pkg::*;

   ssr_ctl_s   ctl_ff, nxt_ctl;
   ssr_eng_s   eng_ff, nxt_eng;
   ssr_pins_s  nxt_pins;
   logic [7:0] nxt_rdData;
   logic       nxt_rxFlag;
   logic       clkSync, datSync;
   logic       mstr, slv, rxMode, txMode, run;
   logic       lead, trail, push, txLoad, rdTop;
   logic [8:0] pushData, rsrTmp;
   logic [3:0] lastBit;
   logic [15:0] div;

   ssr_sync u_clkSync (
      .core_clk (core_clk),
      .reset    (reset),
      .clkEn    (clkEn),
      .asyncIn  (clockPinIn),
      .syncOut  (clkSync)
   );

   ssr_sync u_datSync (
      .core_clk (core_clk),
      .reset    (reset),
      .clkEn    (clkEn),
      .asyncIn  (dataPinIn),
      .syncOut  (datSync)
   );

   assign mstr   = ctl_ff.port_enable & ctl_ff.sync & ctl_ff.clock_source_master;
   assign slv    = ctl_ff.port_enable & ctl_ff.sync & ~ctl_ff.clock_source_master;
   assign rxMode = ctl_ff.single_receive_enable | ctl_ff.continuous_receive_enable;
   assign txMode = ~rxMode & ctl_ff.transmit_enable;
   assign rdTop  = regReq.rd && regReq.addr == ADDR_RXTOP;
   assign div    = ctl_ff.wide_rate_divisor ? {ctl_ff.divHi, ctl_ff.divLo} : {BYTE_ZERO, ctl_ff.divLo};
   assign lastBit = (rxMode ? ctl_ff.rx9 : ctl_ff.tx9) ? LAST_BIT9 : LAST_BIT8;
   // Reception halts while an overrun is pending; transmit runs while the shifter is loaded.
   assign run = (rxMode & ~ctl_ff.overrun_error) | (txMode & eng_ff.busy);
   assign txLoad = (mstr | slv) & txMode & ~eng_ff.busy & ctl_ff.holdFull;

   // Shift engine: clock generation or edge detection, and the shifters.
   always_comb begin
      nxt_eng = eng_ff;
      nxt_eng.clkPrev = clkSync;
      lead = 1'b0;
      trail = 1'b0;
      push = 1'b0;
      rsrTmp = eng_ff.receive_shift_register;
      if (mstr) begin
         case (eng_ff.st)
            ST_IDLE: begin
               if (run) begin
                  lead = 1'b1;
                  nxt_eng.st = ST_ACT;
                  nxt_eng.half = 16'h0000;
               end
            end
            ST_ACT: begin
               if (eng_ff.half == div) begin
                  trail = 1'b1;
                  nxt_eng.st = ST_INACT;
                  nxt_eng.half = 16'h0000;
               end else begin
                  nxt_eng.half = eng_ff.half + 16'h0001;
               end
            end
            ST_INACT: begin
               if (eng_ff.half != div) begin
                  nxt_eng.half = eng_ff.half + 16'h0001;
               end else if (run) begin
                  lead = 1'b1;
                  nxt_eng.st = ST_ACT;
                  nxt_eng.half = 16'h0000;
               end else begin
                  nxt_eng.st = ST_IDLE;
               end
            end
            default: nxt_eng.st = ST_IDLE;
         endcase
         // Dropping the enable mid-character kills the clock and the partial data.
         if (eng_ff.st != ST_IDLE && !txMode && !(rxMode && !ctl_ff.overrun_error)) begin
            nxt_eng.st = ST_IDLE;
            nxt_eng.bitCnt = 4'h0;
            lead = 1'b0;
            trail = 1'b0;
         end
      end else if (slv && run) begin
         // The synced pin is compared with its own delayed copy, not the first stage.
         lead = clkSync != ctl_ff.clock_polarity_select && eng_ff.clkPrev == ctl_ff.clock_polarity_select;
         trail = clkSync == ctl_ff.clock_polarity_select && eng_ff.clkPrev != ctl_ff.clock_polarity_select;
      end else begin
         nxt_eng.st = ST_IDLE;
      end
      if (!(mstr | slv)) begin
         nxt_eng.bitCnt = 4'h0;
         nxt_eng.busy = 1'b0;
      end
      if (txLoad) begin
         nxt_eng.transmit_shifter = {ctl_ff.transmit_ninth_bit, ctl_ff.hold};
         nxt_eng.busy = 1'b1;
         nxt_eng.bitCnt = 4'h0;
      end
      if (lead && txMode) begin
         nxt_eng.datBit = eng_ff.transmit_shifter[eng_ff.bitCnt];
      end
      if (trail) begin
         if (rxMode) begin
            rsrTmp[eng_ff.bitCnt] = datSync;
            nxt_eng.receive_shift_register = rsrTmp;
         end
         if (eng_ff.bitCnt == lastBit) begin
            nxt_eng.bitCnt = 4'h0;
            push = rxMode;
            if (!rxMode) begin
               nxt_eng.busy = 1'b0;
            end
         end else begin
            nxt_eng.bitCnt = eng_ff.bitCnt + 4'h1;
         end
      end
      pushData = ctl_ff.rx9 ? rsrTmp : {1'b0, rsrTmp[7:0]};
   end

   // Control registers, receive FIFO and overrun handling.
   always_comb begin
      nxt_ctl = ctl_ff;
      if (push) begin
         nxt_ctl.single_receive_enable = 1'b0;
      end
      if (txLoad) begin
         nxt_ctl.holdFull = 1'b0;
      end
      if (regReq.wr) begin
         case (regReq.addr)
            ADDR_BAUD: begin
               nxt_ctl.clock_polarity_select = regReq.wdata[B_CLOCK_POLARITY_SELECT];
               nxt_ctl.wide_rate_divisor = regReq.wdata[B_WIDE_RATE_DIVISOR];
            end
            ADDR_RXCTL: begin
               nxt_ctl.port_enable = regReq.wdata[R_PORT_ENABLE];
               nxt_ctl.rx9 = regReq.wdata[R_RX9];
               nxt_ctl.single_receive_enable = regReq.wdata[R_SINGLE_RECEIVE_ENABLE];
               nxt_ctl.continuous_receive_enable = regReq.wdata[R_CONTINUOUS_RECEIVE_ENABLE];
            end
            ADDR_DIVLO: nxt_ctl.divLo = regReq.wdata;
            ADDR_DIVHI: nxt_ctl.divHi = regReq.wdata;
            ADDR_TXHOLD: begin
               nxt_ctl.hold = regReq.wdata;
               nxt_ctl.holdFull = 1'b1;
            end
            ADDR_TXCTL: begin
               nxt_ctl.clock_source_master = regReq.wdata[T_CLOCK_SOURCE_MASTER];
               nxt_ctl.tx9 = regReq.wdata[T_TX9];
               nxt_ctl.transmit_enable = regReq.wdata[T_TRANSMIT_ENABLE];
               nxt_ctl.sync = regReq.wdata[T_SYNC];
               nxt_ctl.high_speed_rate = regReq.wdata[T_HIGH_SPEED_RATE];
               nxt_ctl.transmit_ninth_bit = regReq.wdata[T_TRANSMIT_NINTH_BIT];
            end
            default: ;
         endcase
      end
      if (rdTop && ctl_ff.cnt != 2'h0) begin
         nxt_ctl.rdPtr = ~ctl_ff.rdPtr;
         nxt_ctl.cnt = ctl_ff.cnt - 2'h1;
         if (ctl_ff.oerrSingle) begin
            nxt_ctl.overrun_error = 1'b0;
         end
      end
      if (!ctl_ff.continuous_receive_enable && !ctl_ff.oerrSingle) begin
         nxt_ctl.overrun_error = 1'b0;
      end
      if (push) begin
         if (ctl_ff.cnt == FIFO_FULL) begin
            // The stored characters stay; the new one is thrown away.
            nxt_ctl.overrun_error = 1'b1;
            nxt_ctl.oerrSingle = ~ctl_ff.continuous_receive_enable;
         end else begin
            nxt_ctl.mem[ctl_ff.wrPtr] = pushData;
            nxt_ctl.wrPtr = ~ctl_ff.wrPtr;
            nxt_ctl.cnt = nxt_ctl.cnt + 2'h1;
         end
      end
      if (!ctl_ff.port_enable) begin
         nxt_ctl.overrun_error = 1'b0;
         nxt_ctl.oerrSingle = 1'b0;
         nxt_ctl.cnt = 2'h0;
         nxt_ctl.wrPtr = 1'b0;
         nxt_ctl.rdPtr = 1'b0;
         nxt_ctl.holdFull = 1'b0;
      end
   end

   // Pins, read data and the receive flag, all registered.
   always_comb begin
      nxt_pins.clkOe = mstr;
      nxt_pins.clkOut = (mstr && nxt_eng.st == ST_ACT) ? ~ctl_ff.clock_polarity_select : ctl_ff.clock_polarity_select;
      nxt_pins.datOe = (mstr | slv) & txMode;
      nxt_pins.datOut = nxt_eng.datBit;
      nxt_rxFlag = nxt_ctl.cnt != 2'h0;
      nxt_rdData = BYTE_ZERO;
      if (regReq.rd) begin
         case (regReq.addr)
            ADDR_BAUD: begin
               nxt_rdData[B_IDLE] = eng_ff.st == ST_IDLE && eng_ff.bitCnt == 4'h0;
               nxt_rdData[B_CLOCK_POLARITY_SELECT] = ctl_ff.clock_polarity_select;
               nxt_rdData[B_WIDE_RATE_DIVISOR] = ctl_ff.wide_rate_divisor;
            end
            ADDR_RXCTL: begin
               nxt_rdData[R_PORT_ENABLE] = ctl_ff.port_enable;
               nxt_rdData[R_RX9] = ctl_ff.rx9;
               nxt_rdData[R_SINGLE_RECEIVE_ENABLE] = ctl_ff.single_receive_enable;
               nxt_rdData[R_CONTINUOUS_RECEIVE_ENABLE] = ctl_ff.continuous_receive_enable;
               nxt_rdData[R_OVERRUN_ERROR] = ctl_ff.overrun_error;
               nxt_rdData[R_RECEIVED_NINTH_BIT] = ctl_ff.mem[ctl_ff.rdPtr][8] & rxFlag_ff;
            end
            ADDR_DIVLO: nxt_rdData = ctl_ff.divLo;
            ADDR_DIVHI: nxt_rdData = ctl_ff.divHi;
            ADDR_TXCTL: begin
               nxt_rdData[T_CLOCK_SOURCE_MASTER] = ctl_ff.clock_source_master;
               nxt_rdData[T_TX9] = ctl_ff.tx9;
               nxt_rdData[T_TRANSMIT_ENABLE] = ctl_ff.transmit_enable;
               nxt_rdData[T_SYNC] = ctl_ff.sync;
               nxt_rdData[T_HIGH_SPEED_RATE] = ctl_ff.high_speed_rate;
               nxt_rdData[T_TRMT] = ~eng_ff.busy;
               nxt_rdData[T_TRANSMIT_NINTH_BIT] = ctl_ff.transmit_ninth_bit;
            end
            ADDR_RXTOP: begin
               if (rxFlag_ff) begin
                  nxt_rdData = ctl_ff.mem[ctl_ff.rdPtr][7:0];
               end
            end
            ADDR_STAT: begin
               nxt_rdData[S_HEMPTY] = ~ctl_ff.holdFull;
               nxt_rdData[S_RXFLAG] = rxFlag_ff;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctl_ff <= '0;
         eng_ff <= '0;
         pins_ff <= '0;
         regRdData_ff <= BYTE_ZERO;
         rxFlag_ff <= 1'b0;
      end else if (clkEn) begin
         ctl_ff <= nxt_ctl;
         eng_ff <= nxt_eng;
         pins_ff <= nxt_pins;
         regRdData_ff <= nxt_rdData;
         rxFlag_ff <= nxt_rxFlag;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset || !clkEn);

   sequence s_continuous_receive_enable_drop;
      ctl_ff.continuous_receive_enable && !ctl_ff.single_receive_enable && mstr ##1 !ctl_ff.continuous_receive_enable;
   endsequence

   a_rx_data_off: assert property (mstr && rxMode |=> !pins_ff.datOe)
      else $error("data driver on during master receive");
   a_no_enable_idle: assert property (!rxMode && !txMode
      |=> pins_ff.clkOut == $past(ctl_ff.clock_polarity_select))
      else $error("clock ran with no enable set");
   a_single_clears: assert property (push && !ctl_ff.continuous_receive_enable && !regReq.wr |=> !ctl_ff.single_receive_enable)
      else $error("single receive enable not cleared");
   a_continuous_receive_enable_stop: assert property (s_continuous_receive_enable_drop |=> pins_ff.clkOut == ctl_ff.clock_polarity_select)
      else $error("clock kept running after continuous enable cleared");
   a_push_flag: assert property (push && ctl_ff.cnt == 2'h0 && ctl_ff.port_enable |=> rxFlag_ff)
      else $error("receive flag not raised after character");
   a_slave_clk_off: assert property (slv |=> !pins_ff.clkOe)
      else $error("clock driver on in slave mode");
   a_overrun_set: assert property (push && ctl_ff.cnt == FIFO_FULL && ctl_ff.port_enable
      |=> ctl_ff.overrun_error && ctl_ff.cnt == FIFO_FULL)
      else $error("overrun not flagged or buffer changed");
   a_overrun_read: assert property (ctl_ff.overrun_error && ctl_ff.oerrSingle && rdTop
      |=> !ctl_ff.overrun_error)
      else $error("single-mode overrun not cleared by read");
   a_hold_load: assert property (txLoad |=> eng_ff.busy && eng_ff.bitCnt == 4'h0)
      else $error("holding data not moved to shifter");
   a_pop_top: assert property (rdTop && ctl_ff.cnt == FIFO_FULL && !push && ctl_ff.port_enable
      |=> ctl_ff.cnt == 2'h1)
      else $error("read did not pop the FIFO");
   a_disable_clear: assert property (!ctl_ff.port_enable |=> ctl_ff.cnt == 2'h0 && !ctl_ff.overrun_error)
      else $error("port disable left FIFO or overrun state");

   // A pending overrun must hold off every further character, master or slave alike.
   sequence s_overrun_held;
      ctl_ff.overrun_error && !txMode && ctl_ff.port_enable;
   endsequence

   a_overrun_halt: assert property (s_overrun_held |-> !push)
      else $error("character accepted while overrun pending");
   a_flag_count: assert property (rxFlag_ff == (ctl_ff.cnt != 2'h0))
      else $error("receive flag disagrees with FIFO fill");
   a_nine_length: assert property (trail && rxMode && ctl_ff.rx9
      && eng_ff.bitCnt == LAST_BIT8 |-> !push)
      else $error("nine-bit character closed after eight bits");
   a_tx_data_on: assert property (mstr && txMode |=> pins_ff.datOe)
      else $error("data driver off during master transmit");
   a_slave_no_gen: assert property (slv |=> pins_ff.clkOut == $past(ctl_ff.clock_polarity_select))
      else $error("slave drove its own clock level");
endmodule

// file: ssr_sync.sv
// Two-stage synchroniser for a level arriving from outside the core clock.
`timescale 1ns/1ns
module ssr_sync (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic clkEn,
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic meta_ff;

   // Only the second stage is ever read outside this module.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta_ff <= 1'b0;
         syncOut <= 1'b0;
      end else if (clkEn) begin
         meta_ff <= asyncIn;
         syncOut <= meta_ff;
      end
   end
endmodule

// file: test_ssr_port.sv
// Self-checking bench for the synchronous serial port.
`timescale 1ns/1ns
module test_ssr_port;
   import ssr_pkg::*;
   logic        core_clk;
   logic        reset;
   logic        clkEn;
   ssr_req_s    regReq;
   ssr_pins_s   pins;
   logic [7:0]  rdData;
   logic        rxFlag;
   logic        clock_polarity_select;
   logic        drive;
   logic        txMode;
   logic        rdSeen;
   logic [8:0]  txVal;
   logic [3:0]  nBits;
   logic [8:0]  v [0:1];
   logic [15:0] note;
   logic        clkW;
   logic        datW;
   int          errCount;
   int          checked;
   int          seed;
   int          n;
   int          e0;
   logic [15:0] expRd [$];
   logic [7:0]  expTx [$];

   ssr_port DUT (
      .core_clk     (core_clk),
      .reset        (reset),
      .clkEn        (clkEn),
      .regReq       (regReq),
      .pins_ff      (pins),
      .regRdData_ff (rdData),
      .rxFlag_ff    (rxFlag),
      .clockPinIn   (clkW),
      .dataPinIn    (datW)
   );
   ssr_far_end far (
      .clock_polarity_select  (clock_polarity_select),
      .drive (drive),
      .txVal (txVal),
      .nBits (nBits),
      .pins  (pins),
      .clkW  (clkW),
      .datW  (datW)
   );

   always #10 core_clk = ~core_clk;

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      checked++;
      if (got !== exp) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chkRd(input logic [7:0] exp, input logic [7:0] got);
      chk("read data", {1'b0, exp}, {1'b0, got});
   endtask

   task automatic chkTx(input logic [7:0] exp, input logic [7:0] got);
      chk("sent char", {1'b0, exp}, {1'b0, got});
   endtask

   // One idle cycle follows each strobe, so no signal is assigned twice in a time step.
   task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
      regReq <= '{addr: a, wdata: d, wr: w, rd: ~w};
      @(posedge core_clk);
      regReq <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      expRd.push_back({m, e & m});
      bus(a, 8'h00, 1'b0);
   endtask

   task automatic waitCnt(input int k, input logic onEdges);
      n = 0;
      while ((onEdges ? far.edges : far.frames) < k && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      if (n == 3000) begin
         errCount++;
         stop_test();
      end
      repeat (12) @(posedge core_clk);
   endtask

   always @(posedge core_clk) begin
      if (rdSeen) begin
         note = expRd.pop_front();
         chkRd(note[7:0], rdData & note[15:8]);
      end
      rdSeen <= regReq.rd;
   end

   always @(far.frames) begin
      if (txMode && far.frames != 0) chkTx(expTx.pop_front(), far.rxVal[7:0]);
   end

   initial begin
      #400000;
      errCount++;
      stop_test();
   end

   initial begin
      core_clk = 1'b0;
      reset = 1'b1;
      regReq = '0;
      {clock_polarity_select, txMode, rdSeen} = 3'h0;
      drive = 1'b1;
      clkEn = 1'b1;
      nBits = 4'h8;
      errCount = 0;
      checked = 0;
      seed = 32'h903A3CE2;
      txVal = 9'($random(seed));
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      bus(ADDR_DIVLO, 8'h07, 1'b1);
      bus(ADDR_TXCTL, 8'h90, 1'b1);
      bus(ADDR_RXCTL, 8'h80, 1'b1);
      far.clr();
      repeat (30) @(posedge core_clk);
      chk("clocks unarmed", 9'h000, 9'(far.edges));
      bus(ADDR_RXCTL, 8'hA0, 1'b1);
      waitCnt(1, 1'b0);
      repeat (40) @(posedge core_clk);
      chk("clock pulses", 9'h008, 9'(far.edges));
      chk("data driver", 9'h000, {8'h00, pins.datOe});
      chk("flag", 9'h001, {8'h00, rxFlag});
      rd(ADDR_RXCTL, 8'h80, 8'hF0);
      rd(ADDR_RXTOP, txVal[7:0], 8'hFF);
      chk("flag", 9'h000, {8'h00, rxFlag});
      // Three nine-bit single receives; the third must overrun.
      nBits = 4'h9;
      for (int k = 0; k < 3; k++) begin
         txVal = 9'($random(seed));
         if (k < 2) v[k] = txVal;
         far.clr();
         bus(ADDR_RXCTL, 8'hE0, 1'b1);
         waitCnt(1, 1'b0);
      end
      rd(ADDR_RXCTL, {6'h30, 1'b1, v[0][8]}, 8'hC3);
      rd(ADDR_RXTOP, v[0][7:0], 8'hFF);
      rd(ADDR_RXCTL, {7'h60, v[1][8]}, 8'hC3);
      rd(ADDR_RXTOP, v[1][7:0], 8'hFF);
      chk("flag", 9'h000, {8'h00, rxFlag});
      // Continuous reception, then an abort in mid-character.
      nBits = 4'h8;
      bus(ADDR_RXCTL, 8'h80, 1'b1);
      txVal = 9'($random(seed));
      far.clr();
      bus(ADDR_RXCTL, 8'hB0, 1'b1);
      waitCnt(2, 1'b0);
      rd(ADDR_RXCTL, 8'h90, 8'hF0);
      waitCnt(20, 1'b1);
      bus(ADDR_RXCTL, 8'h80, 1'b1);
      repeat (4) @(posedge core_clk);
      e0 = far.edges;
      chk("idle clock", 9'h000, {8'h00, pins.clkOut});
      repeat (60) @(posedge core_clk);
      chk("clock stopped", 9'(e0), 9'(far.edges));
      rd(ADDR_RXTOP, txVal[7:0], 8'hFF);
      rd(ADDR_RXTOP, txVal[7:0], 8'hFF);
      chk("flag", 9'h000, {8'h00, rxFlag});
      // Continuous overrun survives a FIFO read; disabling the port clears it.
      far.clr();
      bus(ADDR_RXCTL, 8'h90, 1'b1);
      waitCnt(3, 1'b0);
      repeat (60) @(posedge core_clk);
      chk("halted clocks", 9'h018, 9'(far.edges));
      rd(ADDR_RXTOP, txVal[7:0], 8'hFF);
      rd(ADDR_RXCTL, 8'h92, 8'hFE);
      bus(ADDR_RXCTL, 8'h00, 1'b1);
      // The FIFO is emptied one cycle after the disable lands in the control register.
      @(posedge core_clk);
      chk("flag", 9'h000, {8'h00, rxFlag});
      rd(ADDR_RXCTL, 8'h00, 8'hFF);
      // Master transmit in both clock polarities, two characters queued back to back.
      drive = 1'b0;
      txMode = 1'b1;
      bus(ADDR_RXCTL, 8'h80, 1'b1);
      bus(ADDR_TXCTL, 8'hB0, 1'b1);
      for (int p = 0; p < 2; p++) begin
         bus(ADDR_BAUD, p[0] ? 8'h18 : 8'h00, 1'b1);
         clock_polarity_select = p[0];
         repeat (8) @(posedge core_clk);
         chk("idle level", {8'h00, p[0]}, {8'h00, pins.clkOut});
         far.clr();
         for (int k = 0; k < 2; k++) begin
            v[k] = 9'($random(seed)) & 9'h0FF;
            expTx.push_back(v[k][7:0]);
            bus(ADDR_TXHOLD, v[k][7:0], 1'b1);
         end
         rd(ADDR_STAT, 8'h00, 8'h03);
         rd(ADDR_TXCTL, 8'hB0, 8'hF3);
         waitCnt(2, 1'b0);
         chk("tx clocks", 9'h010, 9'(far.edges));
      end
      // Slave reception on a clock made by the far side.
      txMode = 1'b0;
      drive = 1'b1;
      bus(ADDR_BAUD, 8'h00, 1'b1);
      clock_polarity_select = 1'b0;
      bus(ADDR_TXCTL, 8'h10, 1'b1);
      bus(ADDR_RXCTL, 8'h90, 1'b1);
      txVal = 9'($random(seed));
      far.clr();
      #7;
      far.pulses(8);
      @(posedge core_clk);
      repeat (12) @(posedge core_clk);
      chk("clock driver", 9'h000, {8'h00, pins.clkOe});
      rd(ADDR_RXTOP, txVal[7:0], 8'hFF);
      // A write while the clock enable is low must leave the port set up as it was.
      clkEn <= 1'b0;
      bus(ADDR_RXCTL, 8'h00, 1'b1);
      clkEn <= 1'b1;
      rd(ADDR_RXCTL, 8'h90, 8'hF0);
      // Let the last read compare before the verdict.
      repeat (2) @(posedge core_clk);
      stop_test();
   end
endmodule
